//--- logic/ildr_pkg.sv
// Purpose: constants for the input loop divider and receiver configuration block
// Assumes: byte-wide registers behind the serial control port, soft reset defaults
// Notes: every offset, single-bit position, register reset value and divider or current width is named here once
`default_nettype none

package ildr_pkg;
	localparam int ADDR_W = 12;
	localparam int DIV_W = 10;
	localparam int TEST_DIV_W = 6;
	localparam int CUR_W = 7;

	localparam logic [11:0] OFS_SECOND_LOW = 12'h012;
	localparam logic [11:0] OFS_SECOND_HIGH = 12'h013;
	localparam logic [11:0] OFS_TEST_DIV = 12'h014;
	localparam logic [11:0] OFS_RESERVED = 12'h015;
	localparam logic [11:0] OFS_FEEDBACK_LOW = 12'h016;
	localparam logic [11:0] OFS_FEEDBACK_HIGH = 12'h017;
	localparam logic [11:0] OFS_PUMP_CURRENT = 12'h018;
	localparam logic [11:0] OFS_PUMP_MODE = 12'h019;
	localparam logic [11:0] OFS_RX_CONTROL = 12'h01A;
	localparam logic [11:0] OFS_INDEP_CONTROL = 12'h01C;

	localparam logic [7:0] HIGH_BITS_MASK = 8'h03;
	localparam logic [7:0] TEST_DIV_MASK = 8'h3F;
	localparam logic [7:0] PUMP_MODE_MASK = 8'h1F;
	localparam logic [7:0] INDEP_MASK = 8'h80;

	localparam logic [7:0] RST_SECOND_LOW = 8'h00;
	localparam logic [7:0] RST_SECOND_HIGH = 8'h00;
	localparam logic [7:0] RST_TEST_DIV = 8'h00;
	localparam logic [7:0] RST_FEEDBACK_LOW = 8'h00;
	localparam logic [7:0] RST_FEEDBACK_HIGH = 8'h00;
	localparam logic [7:0] RST_PUMP_CURRENT = 8'h00;
	localparam logic [7:0] RST_PUMP_MODE = 8'h0B;
	localparam logic [7:0] RST_RX_CONTROL = 8'h00;
	localparam logic [7:0] RST_INDEP_CONTROL = 8'h00;

	localparam int BIT_PUMP_HIGHZ = 7;
	localparam int BIT_ABL_MANUAL = 4;
	localparam int BIT_ABL_LSB = 2;
	localparam int BIT_INDEP = 7;
	localparam int BIT_TEST_RX_EN = 7;
	localparam int BIT_SECOND_DIFF = 6;
	localparam int BIT_FIRST_DIFF = 5;
	localparam int BIT_SECOND_EN = 4;
	localparam int BIT_FIRST_EN = 3;
	localparam int BIT_PD_CTRL = 2;
	localparam int BIT_OSC_NEG = 1;
	localparam int BIT_OSC_DIFF = 0;

	typedef enum logic [1:0] {
		PUMP_TRISTATE = 2'b00,
		PUMP_UP = 2'b01,
		PUMP_DOWN = 2'b10,
		PUMP_NORMAL = 2'b11
	} ildr_pump_e;

	typedef enum logic [1:0] {
		ABL_MINIMUM = 2'b00,
		ABL_LOW = 2'b01,
		ABL_HIGH = 2'b10,
		ABL_MAXIMUM = 2'b11
	} ildr_abl_e;
endpackage

`default_nettype wire

//--- logic/ildr_sync.sv
// Purpose: bring an outside clock pin into clk and flag its rising edges
// Assumes: pin toggles slower than half of clk
// Notes: first stage feeds only the second stage
`default_nettype none

module ildr_sync (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// pin and edge
	input wire logic pinIn,
	output logic riseOut
);
	logic meta_r;
	logic stable_r;
	logic last_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= 1'b0;
			stable_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= pinIn;
			stable_r <= meta_r;
			last_r <= stable_r;
		end
	end

	assign riseOut = stable_r & ~last_r;
endmodule

`default_nettype wire

//--- logic/ildr_divider.sv
// Purpose: programmable edge divider, one pulse per divisor edges
// Assumes: edge strobe is a one-cycle pulse on clk
// Notes: divisor codes zero and one both give divide-by-one
`default_nettype none

module ildr_divider #(
	parameter int WIDTH = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic softReset,
	// control
	input wire logic [WIDTH-1:0] divisor,
	input wire logic edgeIn,
	// result
	output logic pulseOut
);
	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;
	logic pulse_nxt;
	logic [WIDTH-1:0] lastCount;

	// terminal index; divisor zero folds onto one
	assign lastCount = (divisor == '0) ? '0 : divisor - WIDTH'(1);

	always_comb begin
		count_nxt = count_r;
		pulse_nxt = 1'b0;
		if (edgeIn) begin
			if (count_r >= lastCount) begin
				// terminal test reads the live setting, so a new divisor acts on the running count at once
				count_nxt = '0;
				pulse_nxt = 1'b1;
			end else begin
				count_nxt = count_r + WIDTH'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_r <= '0;
			pulseOut <= 1'b0;
		end else if (softReset) begin
			count_r <= '0;
			pulseOut <= 1'b0;
		end else begin
			count_r <= count_nxt;
			pulseOut <= pulse_nxt;
		end
	end
endmodule

`default_nettype wire

//--- logic/ildr_top.sv
// Purpose: input loop divider and receiver configuration registers
// Assumes: register port driven by the serial control port logic on clk
// Notes: divider clocks arrive as pins and are sampled; reads answer one cycle later
`default_nettype none

module ildr_top (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic softReset,
	// register port from the serial control port
	input wire logic [ildr_pkg::ADDR_W-1:0] regAddr,
	input wire logic regWrite,
	input wire logic [7:0] regWrData,
	input wire logic regRead,
	output logic [7:0] regRdData,
	output logic regRdValid,
	// first reference divisor setting held elsewhere
	input wire logic [ildr_pkg::DIV_W-1:0] firstRefDivisor,
	// clock pins to divide
	input wire logic secondRefClk,
	input wire logic testRefClk,
	input wire logic feedbackClk,
	// divided pulses
	output logic secondRefPulse,
	output logic testRefPulse,
	output logic feedbackPulse,
	// charge pump controls
	output logic pumpHighZ,
	output logic [ildr_pkg::CUR_W-1:0] pumpCurrent,
	output logic [1:0] pumpMode,
	output logic ablAuto,
	output logic [1:0] ablWidth,
	// receiver controls
	output logic testRxEnable,
	output logic secondRxEnable,
	output logic firstRxEnable,
	output logic secondRxDiff,
	output logic firstRxDiff,
	output logic oscRxDiff,
	output logic oscRxNegLeg
);
	logic [7:0] secondLow_r;
	logic [7:0] secondHigh_r;
	logic [7:0] testDiv_r;
	logic [7:0] feedbackLow_r;
	logic [7:0] feedbackHigh_r;
	logic [7:0] pumpCurrent_r;
	logic [7:0] pumpMode_r;
	logic [7:0] rxControl_r;
	logic [7:0] indepControl_r;
	logic [7:0] readMux;
	logic [ildr_pkg::DIV_W-1:0] secondDivisor;
	logic [ildr_pkg::DIV_W-1:0] feedbackDivisor;
	logic secondRise;
	logic testRise;
	logic feedbackRise;
	logic secondPulseRaw;
	logic testPulseRaw;
	logic feedbackPulseRaw;

	function automatic logic hit(input logic [ildr_pkg::ADDR_W-1:0] ofs);
		hit = regWrite && (regAddr == ofs);
	endfunction

	// register writes, reserved bits masked off so they store nothing
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			secondLow_r <= ildr_pkg::RST_SECOND_LOW;
			secondHigh_r <= ildr_pkg::RST_SECOND_HIGH;
		end else if (softReset) begin
			secondLow_r <= ildr_pkg::RST_SECOND_LOW;
			secondHigh_r <= ildr_pkg::RST_SECOND_HIGH;
		end else begin
			if (hit(ildr_pkg::OFS_SECOND_LOW)) begin
				secondLow_r <= regWrData;
			end
			if (hit(ildr_pkg::OFS_SECOND_HIGH)) begin
				secondHigh_r <= regWrData & ildr_pkg::HIGH_BITS_MASK;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			testDiv_r <= ildr_pkg::RST_TEST_DIV;
		end else if (softReset) begin
			testDiv_r <= ildr_pkg::RST_TEST_DIV;
		end else if (hit(ildr_pkg::OFS_TEST_DIV)) begin
			testDiv_r <= regWrData & ildr_pkg::TEST_DIV_MASK;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			feedbackLow_r <= ildr_pkg::RST_FEEDBACK_LOW;
			feedbackHigh_r <= ildr_pkg::RST_FEEDBACK_HIGH;
		end else if (softReset) begin
			feedbackLow_r <= ildr_pkg::RST_FEEDBACK_LOW;
			feedbackHigh_r <= ildr_pkg::RST_FEEDBACK_HIGH;
		end else begin
			if (hit(ildr_pkg::OFS_FEEDBACK_LOW)) begin
				feedbackLow_r <= regWrData;
			end
			if (hit(ildr_pkg::OFS_FEEDBACK_HIGH)) begin
				feedbackHigh_r <= regWrData & ildr_pkg::HIGH_BITS_MASK;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pumpCurrent_r <= ildr_pkg::RST_PUMP_CURRENT;
			pumpMode_r <= ildr_pkg::RST_PUMP_MODE;
		end else if (softReset) begin
			pumpCurrent_r <= ildr_pkg::RST_PUMP_CURRENT;
			pumpMode_r <= ildr_pkg::RST_PUMP_MODE;
		end else begin
			if (hit(ildr_pkg::OFS_PUMP_CURRENT)) begin
				pumpCurrent_r <= regWrData;
			end
			if (hit(ildr_pkg::OFS_PUMP_MODE)) begin
				pumpMode_r <= regWrData & ildr_pkg::PUMP_MODE_MASK;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rxControl_r <= ildr_pkg::RST_RX_CONTROL;
			indepControl_r <= ildr_pkg::RST_INDEP_CONTROL;
		end else if (softReset) begin
			rxControl_r <= ildr_pkg::RST_RX_CONTROL;
			indepControl_r <= ildr_pkg::RST_INDEP_CONTROL;
		end else begin
			if (hit(ildr_pkg::OFS_RX_CONTROL)) begin
				rxControl_r <= regWrData;
			end
			// only the independence bit of this register belongs here
			if (hit(ildr_pkg::OFS_INDEP_CONTROL)) begin
				indepControl_r <= regWrData & ildr_pkg::INDEP_MASK;
			end
		end
	end

	// readback; reserved register and unknown offsets read zero
	always_comb begin
		readMux = 8'h00;
		case (regAddr)
			ildr_pkg::OFS_SECOND_LOW: readMux = secondLow_r;
			ildr_pkg::OFS_SECOND_HIGH: readMux = secondHigh_r;
			ildr_pkg::OFS_TEST_DIV: readMux = testDiv_r;
			ildr_pkg::OFS_RESERVED: readMux = 8'h00;
			ildr_pkg::OFS_FEEDBACK_LOW: readMux = feedbackLow_r;
			ildr_pkg::OFS_FEEDBACK_HIGH: readMux = feedbackHigh_r;
			ildr_pkg::OFS_PUMP_CURRENT: readMux = pumpCurrent_r;
			ildr_pkg::OFS_PUMP_MODE: readMux = pumpMode_r;
			ildr_pkg::OFS_RX_CONTROL: readMux = rxControl_r;
			ildr_pkg::OFS_INDEP_CONTROL: readMux = indepControl_r;
			default: readMux = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			regRdData <= 8'h00;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regRead;
			if (regRead) begin
				regRdData <= readMux;
			end
		end
	end

	// divisor selection
	assign secondDivisor = indepControl_r[ildr_pkg::BIT_INDEP]
		? {secondHigh_r[1:0], secondLow_r}
		: firstRefDivisor;
	assign feedbackDivisor = {feedbackHigh_r[1:0], feedbackLow_r};

	ildr_sync u_sync_second (
		.clk(clk),
		.resetn(resetn),
		.pinIn(secondRefClk),
		.riseOut(secondRise)
	);

	ildr_sync u_sync_test (
		.clk(clk),
		.resetn(resetn),
		.pinIn(testRefClk),
		.riseOut(testRise)
	);

	ildr_sync u_sync_feedback (
		.clk(clk),
		.resetn(resetn),
		.pinIn(feedbackClk),
		.riseOut(feedbackRise)
	);

	ildr_divider #(.WIDTH(ildr_pkg::DIV_W)) u_div_second (
		.clk(clk),
		.resetn(resetn),
		.softReset(softReset),
		.divisor(secondDivisor),
		.edgeIn(secondRise),
		.pulseOut(secondPulseRaw)
	);

	ildr_divider #(.WIDTH(ildr_pkg::TEST_DIV_W)) u_div_test (
		.clk(clk),
		.resetn(resetn),
		.softReset(softReset),
		.divisor(testDiv_r[ildr_pkg::TEST_DIV_W-1:0]),
		.edgeIn(testRise),
		.pulseOut(testPulseRaw)
	);

	ildr_divider #(.WIDTH(ildr_pkg::DIV_W)) u_div_feedback (
		.clk(clk),
		.resetn(resetn),
		.softReset(softReset),
		.divisor(feedbackDivisor),
		.edgeIn(feedbackRise),
		.pulseOut(feedbackPulseRaw)
	);

	// divided pulses leave through a flop so every output is registered
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			secondRefPulse <= 1'b0;
			testRefPulse <= 1'b0;
			feedbackPulse <= 1'b0;
		end else begin
			secondRefPulse <= secondPulseRaw;
			testRefPulse <= testPulseRaw;
			feedbackPulse <= feedbackPulseRaw;
		end
	end

	// charge pump controls
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pumpHighZ <= 1'b0;
			pumpCurrent <= '0;
			pumpMode <= ildr_pkg::PUMP_NORMAL;
			ablAuto <= 1'b1;
			ablWidth <= ildr_pkg::ABL_HIGH;
		end else begin
			// high impedance bit drives pumpHighZ alone; pumpMode still follows the mode field, including pump up or down
			pumpHighZ <= pumpCurrent_r[ildr_pkg::BIT_PUMP_HIGHZ];
			pumpCurrent <= pumpCurrent_r[ildr_pkg::CUR_W-1:0];
			pumpMode <= pumpMode_r[1:0];
			ablAuto <= ~pumpMode_r[ildr_pkg::BIT_ABL_MANUAL];
			ablWidth <= pumpMode_r[ildr_pkg::BIT_ABL_LSB+1:ildr_pkg::BIT_ABL_LSB];
		end
	end

	// receiver controls
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			testRxEnable <= 1'b0;
			secondRxEnable <= 1'b1;
			firstRxEnable <= 1'b1;
			secondRxDiff <= 1'b0;
			firstRxDiff <= 1'b0;
			oscRxDiff <= 1'b0;
			oscRxNegLeg <= 1'b0;
		end else begin
			testRxEnable <= rxControl_r[ildr_pkg::BIT_TEST_RX_EN];
			secondRxDiff <= rxControl_r[ildr_pkg::BIT_SECOND_DIFF];
			firstRxDiff <= rxControl_r[ildr_pkg::BIT_FIRST_DIFF];
			secondRxEnable <= ~rxControl_r[ildr_pkg::BIT_PD_CTRL]
				| rxControl_r[ildr_pkg::BIT_SECOND_EN];
			firstRxEnable <= ~rxControl_r[ildr_pkg::BIT_PD_CTRL]
				| rxControl_r[ildr_pkg::BIT_FIRST_EN];
			oscRxDiff <= rxControl_r[ildr_pkg::BIT_OSC_DIFF];
			// leg choice only meaningful single-ended
			oscRxNegLeg <= ~rxControl_r[ildr_pkg::BIT_OSC_DIFF] & rxControl_r[ildr_pkg::BIT_OSC_NEG];
		end
	end
endmodule

`default_nettype wire

//--- sim/ildr_top_checker.sv
// Purpose: port-level checks of the input loop configuration block
// Assumes: single clock, resetn asynchronous active low
// Notes: derived outputs are judged two edges after the taking edge
`default_nettype none

module ildr_top_checker (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic softReset,
	// register port
	input wire logic [ildr_pkg::ADDR_W-1:0] regAddr,
	input wire logic regWrite,
	input wire logic [7:0] regWrData,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	input wire logic regRdValid,
	// divided pulses
	input wire logic secondRefPulse,
	input wire logic testRefPulse,
	input wire logic feedbackPulse,
	// pump and receiver controls
	input wire logic pumpHighZ,
	input wire logic [ildr_pkg::CUR_W-1:0] pumpCurrent,
	input wire logic [1:0] pumpMode,
	input wire logic ablAuto,
	input wire logic [1:0] ablWidth,
	input wire logic testRxEnable,
	input wire logic secondRxEnable,
	input wire logic firstRxEnable,
	input wire logic secondRxDiff,
	input wire logic firstRxDiff,
	input wire logic oscRxDiff,
	input wire logic oscRxNegLeg
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// write data delayed to line up with the derived outputs
	logic [7:0] wd1;
	logic [7:0] wd2;
	logic [2:0] pulses;
	assign pulses = {secondRefPulse, testRefPulse, feedbackPulse};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wd1 <= 8'h00;
			wd2 <= 8'h00;
		end else begin
			wd1 <= regWrData;
			wd2 <= wd1;
		end
	end

	sequence s_wr(logic [11:0] a);
		regWrite && !softReset && regAddr == a;
	endsequence
	sequence s_rd(logic [11:0] a);
		regRead && regAddr == a;
	endsequence

	property p_rdValid;
		1'b1 |=> regRdValid == $past(regRead);
	endproperty
	property p_rsvdRead;
		s_rd(ildr_pkg::OFS_RESERVED) |=> regRdValid && regRdData == 8'h00;
	endproperty
	property p_rsvdBits;
		regRead && (regAddr == ildr_pkg::OFS_TEST_DIV || regAddr == ildr_pkg::OFS_PUMP_MODE) |=> regRdData[7:6] == 2'h0;
	endproperty
	property p_current;
		s_wr(ildr_pkg::OFS_PUMP_CURRENT) |-> ##2 pumpHighZ == wd2[7] && pumpCurrent == wd2[6:0];
	endproperty
	property p_mode;
		s_wr(ildr_pkg::OFS_PUMP_MODE) |-> ##2 pumpMode == wd2[1:0] && ablAuto == !wd2[4] && ablWidth == wd2[3:2];
	endproperty
	property p_rxMode;
		s_wr(ildr_pkg::OFS_RX_CONTROL) |-> ##2 {testRxEnable, secondRxDiff, firstRxDiff, oscRxDiff} == {wd2[7:5], wd2[0]};
	endproperty
	property p_rxPower;
		s_wr(ildr_pkg::OFS_RX_CONTROL) |-> ##2 firstRxEnable == (!wd2[2] || wd2[3]) && secondRxEnable == (!wd2[2] || wd2[4]);
	endproperty
	property p_oscLeg;
		s_wr(ildr_pkg::OFS_RX_CONTROL) |-> ##2 oscRxNegLeg == (!wd2[0] && wd2[1]);
	endproperty
	property p_softDefault;
		softReset |-> ##2 pumpMode == 2'h3 && ablAuto && ablWidth == 2'h2 && !pumpHighZ && !testRxEnable
			&& firstRxEnable && secondRxEnable;
	endproperty
	property p_pulse;
		pulses != 3'h0 |=> (pulses & $past(pulses)) == 3'h0;
	endproperty

	a_rdValid: assert property (p_rdValid) else $error("read valid not one cycle after read");
	a_rsvdRead: assert property (p_rsvdRead) else $error("reserved register read not zero");
	a_rsvdBits: assert property (p_rsvdBits) else $error("reserved bits read not zero");
	a_current: assert property (p_current) else $error("pump current or high impedance wrong");
	a_mode: assert property (p_mode) else $error("pump mode or antibacklash wrong");
	a_rxMode: assert property (p_rxMode) else $error("receiver mode bits wrong");
	a_rxPower: assert property (p_rxPower) else $error("receiver enables wrong");
	a_oscLeg: assert property (p_oscLeg) else $error("oscillator leg select wrong");
	a_softDefault: assert property (p_softDefault) else $error("soft reset defaults wrong");
	a_pulse: assert property (p_pulse) else $error("divider pulse longer than one cycle");
endmodule

bind ildr_top ildr_top_checker u_ildr_top_checker (.clk(clk), .resetn(resetn), .softReset(softReset),
	.regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
	.regRdValid(regRdValid), .secondRefPulse(secondRefPulse), .testRefPulse(testRefPulse),
	.feedbackPulse(feedbackPulse), .pumpHighZ(pumpHighZ), .pumpCurrent(pumpCurrent), .pumpMode(pumpMode),
	.ablAuto(ablAuto), .ablWidth(ablWidth), .testRxEnable(testRxEnable), .secondRxEnable(secondRxEnable),
	.firstRxEnable(firstRxEnable), .secondRxDiff(secondRxDiff), .firstRxDiff(firstRxDiff),
	.oscRxDiff(oscRxDiff), .oscRxNegLeg(oscRxNegLeg));

`default_nettype wire

//--- sim/ildr_top_tb_top.sv
// Purpose: directed bench for the input loop configuration block
// Assumes: inputs change on the falling edge, checks sample there too, divided pulses are counted on the rising edge
// Notes: divider counts are cleared by soft reset before each run
`default_nettype none

`define CHK(nm, ex, gt) begin totalChecks++; if ((gt) !== (ex)) begin errCount++; \
	$display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end

module ildr_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic softReset = 1'b0;
	logic [11:0] regAddr = 12'h000;
	logic regWrite = 1'b0;
	logic [7:0] regWrData = 8'h00;
	logic regRead = 1'b0;
	logic [9:0] firstRefDivisor = 10'h003;
	logic [2:0] pins = 3'h0;
	logic [7:0] regRdData, v;
	logic [6:0] pumpCurrent;
	logic [1:0] pumpMode, ablWidth;
	logic regRdValid, secondRefPulse, testRefPulse, feedbackPulse, pumpHighZ, ablAuto;
	logic testRxEnable, secondRxEnable, firstRxEnable, secondRxDiff, firstRxDiff, oscRxDiff, oscRxNegLeg;
	int errCount = 0;
	int totalChecks = 0;
	int cnt2, cntT, cntF, i;
	// 0x0FF stands for an unmapped address
	logic [11:0] addrs [11] = '{12'h012, 12'h013, 12'h014, 12'h015, 12'h016, 12'h017, 12'h018, 12'h019,
		12'h01A, 12'h01C, 12'h0FF};
	logic [7:0] maskv [11] = '{8'hFF, 8'h03, 8'h3F, 8'h00, 8'hFF, 8'h03, 8'hFF, 8'h1F, 8'hFF, 8'h80, 8'h00};

	ildr_top u_ildr_top (.clk(clk), .resetn(resetn), .softReset(softReset), .regAddr(regAddr),
		.regWrite(regWrite), .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
		.regRdValid(regRdValid), .firstRefDivisor(firstRefDivisor), .secondRefClk(pins[2]),
		.testRefClk(pins[1]), .feedbackClk(pins[0]), .secondRefPulse(secondRefPulse),
		.testRefPulse(testRefPulse), .feedbackPulse(feedbackPulse), .pumpHighZ(pumpHighZ),
		.pumpCurrent(pumpCurrent), .pumpMode(pumpMode), .ablAuto(ablAuto), .ablWidth(ablWidth),
		.testRxEnable(testRxEnable), .secondRxEnable(secondRxEnable), .firstRxEnable(firstRxEnable),
		.secondRxDiff(secondRxDiff), .firstRxDiff(firstRxDiff), .oscRxDiff(oscRxDiff),
		.oscRxNegLeg(oscRxNegLeg));

	initial begin
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (secondRefPulse === 1'b1) cnt2++;
		if (testRefPulse === 1'b1) cntT++;
		if (feedbackPulse === 1'b1) cntF++;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", totalChecks, errCount);
		if (errCount == 0 && totalChecks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk);
		regAddr = a;
		regWrData = d;
		regWrite = 1'b1;
		@(negedge clk);
		regWrite = 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		int k;
		@(negedge clk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge clk);
		regRead = 1'b0;
		for (k = 0; k < 4 && regRdValid !== 1'b1; k++) @(negedge clk);
		if (regRdValid !== 1'b1) begin
			errCount++;
			conclude();
		end
		d = regRdData;
	endtask

	// pins stay low around soft reset so no stray edge is counted
	task automatic prep();
		@(negedge clk);
		softReset = 1'b1;
		@(negedge clk);
		softReset = 1'b0;
		cnt2 = 0;
		cntT = 0;
		cntF = 0;
	endtask

	// four clocks per pin period, well under the half-rate limit
	task automatic edges(input int n);
		int k;
		for (k = 0; k < n; k++) begin
			@(negedge clk);
			pins = 3'h7;
			repeat (2) @(negedge clk);
			pins = 3'h0;
			@(negedge clk);
		end
		repeat (8) @(negedge clk);
	endtask

	initial begin
		repeat (16) @(negedge clk);
		resetn = 1'b1;
		@(negedge clk);
		`CHK("pumpDefaults", 5'h1B, {ablAuto, ablWidth, pumpMode})
		`CHK("rxEnables", 3'h3, {testRxEnable, secondRxEnable, firstRxEnable})
		`CHK("rxModes", 4'h0, {secondRxDiff, firstRxDiff, oscRxDiff, oscRxNegLeg})
		for (i = 0; i < 11; i++) begin
			rd(addrs[i], v);
			`CHK("resetValue", (i == 7) ? 8'h0B : 8'h00, v)
		end
		for (i = 0; i < 11; i++) wr(addrs[i], 8'hFF);
		for (i = 0; i < 11; i++) begin
			rd(addrs[i], v);
			`CHK("maskedValue", maskv[i], v)
		end
		for (i = 0; i < 256; i++) begin
			wr(12'h018, i[7:0]);
			wr(12'h01A, i[7:0]);
			wr(12'h019, i[7:0]);
			repeat (2) @(negedge clk);
			`CHK("pump", i[7:0], {pumpHighZ, pumpCurrent})
			`CHK("mode", {~i[4], i[3:0]}, {ablAuto, ablWidth, pumpMode})
			`CHK("rxMode", {i[7:5], i[0], ~i[0] & i[1]}, {testRxEnable, secondRxDiff, firstRxDiff, oscRxDiff, oscRxNegLeg})
			`CHK("rxPower", {~i[2] | i[4], ~i[2] | i[3]}, {secondRxEnable, firstRxEnable})
		end
		prep();
		rd(12'h019, v);
		`CHK("softDefault", 8'h0B, v)
		wr(12'h012, 8'h05);
		wr(12'h016, 8'h05);
		edges(15);
		`CHK("secondShared", 5, cnt2)
		`CHK("testByOne", 15, cntT)
		`CHK("feedback", 3, cntF)
		prep();
		wr(12'h01C, 8'h80);
		wr(12'h012, 8'h02);
		wr(12'h013, 8'h01);
		wr(12'h014, 8'h3F);
		wr(12'h016, 8'h01);
		edges(520);
		`CHK("secondOwn", 2, cnt2)
		`CHK("testMax", 8, cntT)
		`CHK("feedbackOne", 520, cntF)
		conclude();
	end
endmodule

`default_nettype wire
